// *** logic/qdac_serial_port.v ***
`timescale 1ns/1ps
`include "qdac_consts.vh"
module qdac_serial_port #(
  parameter CODE_W = `QDAC_CODE_W
) (
  input  wire              clk_in,
  input  wire              nrst_in,
  input  wire              frame_n_in,
  input  wire              sclk_in,
  input  wire              sdata_in,
  output reg  [4*CODE_W-1:0] out_codes_out,
  output reg               powered_down_out,
  output reg  [1:0]        term_sel_out,
  output reg               frame_done_out
);
  ////////////////////////////////////////////////////////////////////////////
  // Constants
  localparam integer     CNT_W    = `QDAC_CNT_W;
  localparam integer     FRAME_W  = `QDAC_FRAME_BITS;
  localparam integer     LAST_I   = `QDAC_FRAME_BITS - 1;
  localparam [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};
  localparam [CNT_W-1:0] CNT_ONE  = {{(CNT_W-1){1'b0}}, 1'b1};
  localparam [2:0]       PIN_IDLE = 3'h4;
  localparam [2:0]       ST_IDLE  = 3'h1;
  localparam [2:0]       ST_SHIFT = 3'h2;
  localparam [2:0]       ST_DONE  = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: frame, clock and data pins, two flip-flops each
  wire [2:0] pin_raw;
  wire [2:0] pin_sync;
  assign pin_raw = {frame_n_in, sclk_in, sdata_in};

  genvar p;
  generate
    for (p = 0; p < 3; p = p + 1) begin : g_sync
      reg meta;
      reg sync;
      always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          meta <= PIN_IDLE[p];
          sync <= PIN_IDLE[p];
        end else begin
          meta <= pin_raw[p];
          sync <= meta;
        end
      end
      assign pin_sync[p] = sync;
    end
  endgenerate

  wire frame_act = ~pin_sync[2];
  wire sclk_now  = pin_sync[1];
  wire data_now  = pin_sync[0];

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock falling edge; reset level matches the idle low clock
  reg  sclk_prev;
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= sclk_now;
    end
  end
  wire sclk_fall = sclk_prev & ~sclk_now;

  ////////////////////////////////////////////////////////////////////////////
  // Frame state: idle, shifting, done (later edges ignored)
  reg  [2:0]         state;
  reg  [2:0]         next_state;
  reg  [CNT_W-1:0]   bit_cnt;
  reg  [FRAME_W-1:0] shreg;
  wire [31:0]        bit_cnt_w = {{(32-CNT_W){1'b0}}, bit_cnt};
  wire               shifting  = frame_act && sclk_fall && (state != ST_DONE);
  wire               last_edge = shifting && (bit_cnt_w == LAST_I);
  wire [FRAME_W-1:0] word      = {shreg[FRAME_W-2:0], data_now};

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (frame_act) begin
          next_state = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (!frame_act) begin
          next_state = ST_IDLE;
        end else if (last_edge) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        if (!frame_act) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift register and bit count
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      shreg   <= {FRAME_W{1'b0}};
      bit_cnt <= CNT_ZERO;
    end else if (!frame_act) begin
      bit_cnt <= CNT_ZERO;
    end else if (shifting) begin
      shreg   <= word;
      bit_cnt <= bit_cnt + CNT_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode
  wire [1:0]        sel  = {word[`QDAC_SEL_HI_BIT], word[`QDAC_SEL_LO_BIT]};
  wire [1:0]        act  = {word[`QDAC_ACT_HI_BIT], word[`QDAC_ACT_LO_BIT]};
  wire [CODE_W-1:0] code = word[`QDAC_DATA_MSB:`QDAC_CODE_LSB];
  reg               wr_one;
  reg               wr_all;
  reg               do_upd;
  reg               do_pd;
  reg  [1:0]        pd_term;

  always @* begin
    wr_one = 1'b0;
    wr_all = 1'b0;
    do_upd = 1'b0;
    do_pd  = 1'b0;
    case (act)
      `QDAC_ACT_LOAD: begin
        wr_one = last_edge;
      end
      `QDAC_ACT_LOAD_UPD: begin
        wr_one = last_edge;
        do_upd = last_edge;
      end
      `QDAC_ACT_ALL_UPD: begin
        wr_all = last_edge;
        do_upd = last_edge;
      end
      `QDAC_ACT_PDOWN: begin
        do_pd = last_edge;
      end
      default: begin
        do_pd = 1'b0;
      end
    endcase
  end

  // Address 11 in power-down falls back to high impedance
  always @* begin
    case (sel)
      `QDAC_TERM_2K5: begin
        pd_term = `QDAC_TERM_2K5;
      end
      `QDAC_TERM_100K: begin
        pd_term = `QDAC_TERM_100K;
      end
      default: begin
        pd_term = `QDAC_TERM_HIZ;
      end
    endcase
  end

  wire [4*CODE_W-1:0] held_codes;
  qdac_code_store #(
    .W (CODE_W)
  ) u_store (
    .clk_in       (clk_in),
    .nrst_in      (nrst_in),
    .wr_all_in    (wr_all),
    .wr_one_in    (wr_one),
    .wr_sel_in    (sel),
    .wr_code_in   (code),
    .rd_codes_out (held_codes)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Output stage: on update commands, codes follow the store one cycle after its write
  reg upd_pend;
  reg wake_pend;

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      upd_pend       <= 1'b0;
      wake_pend      <= 1'b0;
      frame_done_out <= 1'b0;
    end else begin
      upd_pend       <= do_upd;
      wake_pend      <= last_edge && !do_pd;
      frame_done_out <= last_edge;
    end
  end

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      powered_down_out <= 1'b0;
      term_sel_out     <= `QDAC_TERM_HIZ;
    end else if (do_pd) begin
      powered_down_out <= 1'b1;
      term_sel_out     <= pd_term;
    end else if (wake_pend) begin
      powered_down_out <= 1'b0;
    end
  end

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      out_codes_out <= {4*CODE_W{1'b0}};
    end else if (upd_pend) begin
      out_codes_out <= held_codes;
    end
  end
endmodule // qdac_serial_port

// *** logic/qdac_consts.vh ***
`ifndef QDAC_CONSTS_VH
`define QDAC_CONSTS_VH
`define QDAC_FRAME_BITS     16
`define QDAC_CNT_W          5
`define QDAC_CODE_W         10
`define QDAC_SEL_HI_BIT     15
`define QDAC_SEL_LO_BIT     14
`define QDAC_ACT_HI_BIT     13
`define QDAC_ACT_LO_BIT     12
`define QDAC_DATA_MSB       11
`define QDAC_CODE_LSB       2
`define QDAC_ACT_LOAD       2'h0
`define QDAC_ACT_LOAD_UPD   2'h1
`define QDAC_ACT_ALL_UPD    2'h2
`define QDAC_ACT_PDOWN      2'h3
`define QDAC_TERM_HIZ       2'h0
`define QDAC_TERM_2K5       2'h1
`define QDAC_TERM_100K      2'h2
`define QDAC_CODE_RST       10'h000
`endif

// *** logic/qdac_code_store.v ***
`timescale 1ns/1ps
`include "qdac_consts.vh"
// Four channel codes; read data are registered
module qdac_code_store #(
  parameter W = 10
) (
  input  wire         clk_in,
  input  wire         nrst_in,
  input  wire         wr_all_in,
  input  wire         wr_one_in,
  input  wire [1:0]   wr_sel_in,
  input  wire [W-1:0] wr_code_in,
  output reg  [4*W-1:0] rd_codes_out
);
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_ch
      always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          rd_codes_out[i*W +: W] <= {W{1'b0}};
        end else if (wr_all_in || (wr_one_in && wr_sel_in == i)) begin
          rd_codes_out[i*W +: W] <= wr_code_in;
        end
      end
    end
  endgenerate
endmodule // qdac_code_store

// *** dv/qdac_host_model.sv ***
`timescale 1ns/1ps
module qdac_host_model (
  input  logic clk_in,
  output logic frame_n_out = 1'h0,
  output logic sclk_out    = 1'h0,
  output logic sdata_out   = 1'h0
);
  // Pins change only just after a rising system clock edge
  task automatic tick(input int c);
    repeat (c) @(posedge clk_in);
  endtask
  // Serial clock period is eight system clocks (400 ns)
  task automatic send(input logic [31:0] w, input int n);
    tick(1);
    frame_n_out <= 1'h1;
    tick(10);
    frame_n_out <= 1'h0;
    for (int i = 0; i < n; i++) begin
      tick(4);
      sdata_out <= w[31-i];
      sclk_out  <= 1'h1;
      tick(4);
      sclk_out  <= 1'h0;
    end
    tick(4);
    frame_n_out <= 1'h1;
    sdata_out   <= 1'h0;
    tick(10);
    frame_n_out <= 1'h0;
  endtask
endmodule // qdac_host_model

// *** dv/qdac_chk.sv ***
`timescale 1ns/1ps
module qdac_chk #(parameter CODE_W = 10) (
  input wire                clk_in,
  input wire                nrst_in,
  input wire [4*CODE_W-1:0] out_codes_out,
  input wire                powered_down_out,
  input wire [1:0]          term_sel_out,
  input wire                frame_done_out
);
  default clocking @(posedge clk_in); endclocking default disable iff (!nrst_in);
  sequence s_hold; $stable(out_codes_out) [*2]; endsequence
  sequence s_done_now; frame_done_out; endsequence
  property p_rst; $rose(nrst_in) |-> !out_codes_out && !powered_down_out; endproperty
  a_rst: assert property (p_rst) else $error("outputs not clear");
  property p_one; frame_done_out |=> !frame_done_out [*8]; endproperty
  a_one: assert property (p_one) else $error("done repeated");
  property p_cod; $changed(out_codes_out) |-> $past(frame_done_out); endproperty
  a_cod: assert property (p_cod) else $error("codes moved");
  property p_pd_on; $rose(powered_down_out) |-> s_done_now; endproperty
  a_pd_on: assert property (p_pd_on) else $error("power down without frame");
  property p_pd_off; $fell(powered_down_out) |-> $past(frame_done_out); endproperty
  a_pd_off: assert property (p_pd_off) else $error("wake without frame");
  property p_term; $changed(term_sel_out) |-> s_done_now ##0 powered_down_out; endproperty
  a_term: assert property (p_term) else $error("termination moved");
  property p_kep; $rose(powered_down_out) |-> s_hold; endproperty
  a_kep: assert property (p_kep) else $error("codes lost");
endmodule // qdac_chk
bind qdac_serial_port qdac_chk #(.CODE_W(CODE_W)) u_chk (.*);

// *** dv/tb.sv ***
`timescale 1ns/1ps
module tb;
  logic       clk_in = 1'h0, nrst_in = 1'h0;
  logic [9:0] st [4] = '{default: 10'h000}, ex [4] = '{default: 10'h000};
  wire        frame_n_in, sclk_in, sdata_in, powered_down_out, frame_done_out;
  wire [39:0] out_codes_out;
  wire [1:0]  term_sel_out;
  int         n_mismatch = 0, checked = 0, cyc = 0, nd = 0, ed = 0, n, w, e_m = 0;
  qdac_serial_port DUT (.*);
  qdac_host_model host (.clk_in(clk_in), .frame_n_out(frame_n_in), .sclk_out(sclk_in),
                        .sdata_out(sdata_in));
  initial forever #25 clk_in = ~clk_in;
  always @(posedge clk_in) nd <= nd + (frame_done_out === 1'h1);
  always @(posedge clk_in) if (++cyc > 20000) print_verdict();
  task chk(input string s, input logic [79:0] e, input logic [79:0] v);
    checked++;
    if (v !== e) $display("unexpected %s expected %h seen %h", s, e, v);
    n_mismatch += (v !== e);
  endtask
  task print_verdict();
    n_mismatch += (cyc > 20000);
    if (n_mismatch == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    void'($urandom(15938));
    repeat (20) @(posedge clk_in);
    nrst_in <= 1'h1;
    for (int i = 0; i < 41; i++) begin
      chk("state", {ex[3], ex[2], ex[1], ex[0], e_m[2:0], ed[7:0]}, {out_codes_out, term_sel_out & {2{e_m[0]}}, powered_down_out, nd[7:0]});
      w = (i == 0) ? 32'h2ffc_0000 : (i == 1) ? 32'h7000_0000 : (i == 2) ? 32'h1000_0000 : $urandom;
      n = (i % 5 == 4) ? 24 : (i % 7 == 6) ? 15 - i % 3 : 16;
      host.send(w, n);
      ed += (n > 15);
      if (n > 15) e_m = (w[29:28] == 2'h3) ? {w[31:30] % 2'h3, 1'h1} : 0;
      foreach (st[k]) if (n > 15 && (w[29:28] == 2'h2 || w[29:28] < 2'h2 && k == w[31:30])) st[k] = w[27:18];
      if (n > 15 && (w[29:28] == 2'h1 || w[29:28] == 2'h2)) ex = st;
    end
    chk("state", {ex[3], ex[2], ex[1], ex[0], e_m[2:0], ed[7:0]}, {out_codes_out, term_sel_out & {2{e_m[0]}}, powered_down_out, nd[7:0]});
    nrst_in <= 1'h0;
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'h1;
    repeat (2) @(posedge clk_in);
    chk("reset", 80'h0, {out_codes_out, term_sel_out, powered_down_out, frame_done_out});
    print_verdict();
  end
endmodule // tb
